// >>> mhb_pkg.sv
package mhb_pkg;
   // ***********************************
   // Register addresses on the muxed bus
   // ***********************************
   localparam logic [7:0] ADDR_MASTER_IRQ_CTL = 8'h09;
   localparam logic [7:0] ADDR_EXT_FEATURE = 8'h07;
   localparam logic [7:0] ADDR_MISC_STATUS = 8'h0a;
   localparam logic [7:0] ADDR_EXT_READBACK = 8'h0e;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h0f;
   localparam logic [7:0] ADDR_EXT_WRITE = 8'h11;
   // ***********************************
   // Field positions and reset values
   // ***********************************
   localparam int NO_VECTOR_BIT = 1;
   localparam int EXT_READ_EN_BIT = 6;
   localparam int UNUSED_RB_BIT = 7;
   localparam logic [7:0] EXT_FEATURE_RESET = 8'h20;
   localparam logic [7:0] MISC_STATUS_RESET = 8'h20;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam logic [7:0] MASTER_IRQ_RESET = 8'h00;
   localparam logic [7:0] VECTOR_RESET = 8'h00;
   // ***********************************
   // Timing
   // ***********************************
   localparam int RECOVERY_PCLKS = 4;
   localparam int SYNC_STAGES = 2;
endpackage : mhb_pkg

// >>> mhb_sync.sv
`timescale 1ns/1ps
module mhb_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : mhb_sync

// >>> mhb_port.sv
`timescale 1ns/1ps
module mhb_port
   import mhb_pkg::*;
#(
   parameter int IRQ_SRCS = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Host bus pins
   input wire logic address_strobe_n,
   input wire logic data_strobe_n,
   input wire logic latched_select_low,
   input wire logic chip_select_high,
   input wire logic rw,
   input wire logic irq_ack_n,
   input wire logic chain_priority_in,
   input wire logic [7:0] muxed_addr_data_in,
   output logic [7:0] muxed_addr_data_out,
   output logic muxed_addr_data_oe,
   output logic int_req_n,
   // Channel side
   input wire logic [IRQ_SRCS-1:0] irq_src,
   input wire logic [IRQ_SRCS-1:0] ius_clear,
   input wire logic [7:0] misc_status_in,
   output logic [IRQ_SRCS-1:0] in_service_latch,
   output logic [7:0] ext_write_settings,
   output logic access_overrun
);
   typedef enum logic [1:0] {
      MHB_IDLE = 2'b00,
      MHB_ACCESS = 2'b01,
      MHB_ACK = 2'b10
   } mhb_state_t;

   // ***********************************
   // Pin synchronisers
   // ***********************************
   // Active-low pins enter inverted so the cleared synchroniser matches their idle level;
   // otherwise the edge detectors would see a false strobe edge just after reset
   logic [12:0] sync_q;
   mhb_sync #(.WIDTH(13)) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .d({~address_strobe_n, ~data_strobe_n, ~latched_select_low, chip_select_high, rw,
          ~irq_ack_n, chain_priority_in, muxed_addr_data_in[5:0]}),
      .q(sync_q)
   );
   // Top two address bits passed separately to keep the sync vector narrow
   logic [1:0] addr_hi_q;
   mhb_sync #(.WIDTH(2)) u_sync_hi (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .d(muxed_addr_data_in[7:6]),
      .q(addr_hi_q)
   );
   wire as_s = ~sync_q[12];
   wire ds_s = ~sync_q[11];
   wire cs0_s = ~sync_q[10];
   wire cs1_s = sync_q[9];
   wire rw_s = sync_q[8];
   wire ack_s = ~sync_q[7];
   wire iei_s = sync_q[6];
   wire [7:0] ad_s = {addr_hi_q, sync_q[5:0]};

   logic as_d1_q, ds_d1_q;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         as_d1_q <= 1'b1;
         ds_d1_q <= 1'b1;
      end else begin
         as_d1_q <= as_s;
         ds_d1_q <= ds_s;
      end
   end
   wire as_rise = as_s & ~as_d1_q;
   wire ds_fall = ~ds_s & ds_d1_q;
   wire ds_rise = ds_s & ~ds_d1_q;

   // ***********************************
   // Address phase capture
   // ***********************************
   logic [7:0] addr_q;
   logic ack_cyc_q, cs0_q;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         addr_q <= 8'h00;
         ack_cyc_q <= 1'b0;
         cs0_q <= 1'b1;
      end else if (as_rise) begin
         addr_q <= ad_s;
         ack_cyc_q <= ~ack_s;
         cs0_q <= cs0_s;
      end
   end

   // ***********************************
   // Registers
   // ***********************************
   logic [7:0] master_irq_ctl_reg_q, extended_feature_reg_q, irq_en_q, ext_write_q;
   logic [IRQ_SRCS-1:0] int_pending_bit_q, ius_q;
   logic [7:0] misc_status_q;
   mhb_state_t state_q;

   // Plain access only when not an acknowledge and both selects agree
   wire dev_sel = ~ack_cyc_q & ~cs0_q & cs1_s;
   wire wr_strobe = ds_fall & (state_q == MHB_IDLE) & dev_sel & ~rw_s;
   wire rd_strobe = ds_fall & (state_q == MHB_IDLE) & dev_sel & rw_s;
   wire claim_ack = ds_fall & (state_q == MHB_IDLE) & ack_cyc_q & iei_s
                    & (|int_pending_bit_q);

   function automatic logic [IRQ_SRCS-1:0] first_one(input logic [IRQ_SRCS-1:0] v);
      logic [IRQ_SRCS-1:0] r;
      r = '0;
      for (int i = IRQ_SRCS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction : first_one

   wire [IRQ_SRCS-1:0] grant = first_one(int_pending_bit_q);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         master_irq_ctl_reg_q <= MASTER_IRQ_RESET;
         extended_feature_reg_q <= EXT_FEATURE_RESET;
         irq_en_q <= IRQ_EN_RESET;
         ext_write_q <= 8'h00;
         misc_status_q <= MISC_STATUS_RESET;
      end else begin
         misc_status_q <= misc_status_in;
         if (wr_strobe) begin
            if (addr_q == ADDR_MASTER_IRQ_CTL) master_irq_ctl_reg_q <= ad_s;
            else if (addr_q == ADDR_EXT_FEATURE) extended_feature_reg_q <= ad_s;
            else if (addr_q == ADDR_IRQ_EN) irq_en_q <= ad_s;
            else if (addr_q == ADDR_EXT_WRITE) ext_write_q <= ad_s;
         end
      end
   end

   // ***********************************
   // Interrupt pending and in-service
   // ***********************************
   // Sources are sampled only on address strobes, so a quiet bus delays requests
   wire [IRQ_SRCS-1:0] en_src = irq_src & irq_en_q[IRQ_SRCS-1:0];
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         int_pending_bit_q <= '0;
         ius_q <= '0;
      end else begin
         if (as_rise) int_pending_bit_q <= en_src & ~ius_q;
         else if (claim_ack) int_pending_bit_q <= int_pending_bit_q & ~grant;
         // Set wins over a same-cycle clear
         ius_q <= (ius_q & ~ius_clear) | (claim_ack ? grant : '0);
      end
   end

   // ***********************************
   // Read data and bus drive
   // ***********************************
   wire ext_rd_en = extended_feature_reg_q[EXT_READ_EN_BIT];
   wire [7:0] ext_rb = {1'b0, ext_write_q[6:0]};
   wire [7:0] rd_mux = (addr_q == ADDR_EXT_READBACK) ? (ext_rd_en ? ext_rb : misc_status_q) :
                       (addr_q == ADDR_IRQ_EN) ? irq_en_q :
                       (addr_q == ADDR_MASTER_IRQ_CTL) ? master_irq_ctl_reg_q :
                       (addr_q == ADDR_MISC_STATUS) ? misc_status_q : 8'h00;
   wire [7:0] vector = {VECTOR_RESET[7:IRQ_SRCS], grant};
   wire vec_ok = ~master_irq_ctl_reg_q[NO_VECTOR_BIT];

   // ***********************************
   // Access tracking and recovery
   // ***********************************
   logic [2:0] rec_cnt_q;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= MHB_IDLE;
         muxed_addr_data_out <= 8'h00;
         muxed_addr_data_oe <= 1'b0;
         int_req_n <= 1'b1;
         rec_cnt_q <= 3'd0;
         access_overrun <= 1'b0;
      end else begin
         int_req_n <= ~(|int_pending_bit_q) | claim_ack;
         if (rec_cnt_q != 3'd0) rec_cnt_q <= rec_cnt_q - 3'd1;
         // Only device accesses restart the window
         if (wr_strobe | rd_strobe | claim_ack) begin
            rec_cnt_q <= 3'(RECOVERY_PCLKS - 1);
            access_overrun <= (rec_cnt_q != 3'd0);
         end
         case (state_q)
            MHB_IDLE: begin
               muxed_addr_data_oe <= 1'b0;
               if (rd_strobe) begin
                  state_q <= MHB_ACCESS;
                  muxed_addr_data_out <= rd_mux;
                  muxed_addr_data_oe <= 1'b1;
               end else if (claim_ack) begin
                  state_q <= MHB_ACK;
                  muxed_addr_data_out <= vector;
                  muxed_addr_data_oe <= vec_ok;
               end else if (ds_fall) begin
                  state_q <= MHB_ACCESS;
               end
            end
            MHB_ACCESS, MHB_ACK: begin
               if (ds_rise | ~cs1_s & ~ack_cyc_q) muxed_addr_data_oe <= 1'b0;
               if (ds_rise) state_q <= MHB_IDLE;
            end
            default: state_q <= MHB_IDLE;
         endcase
      end
   end

   assign in_service_latch = ius_q;
   assign ext_write_settings = ext_write_q;
endmodule : mhb_port

// >>> mhb_port_props.sv
`timescale 1ns/1ps
module mhb_port_props
   import mhb_pkg::*;
#(
   parameter int IRQ_SRCS = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Host bus pins
   input wire logic address_strobe_n,
   input wire logic data_strobe_n,
   input wire logic chip_select_high,
   input wire logic rw,
   input wire logic irq_ack_n,
   input wire logic chain_priority_in,
   input wire logic muxed_addr_data_oe,
   input wire logic int_req_n,
   // Channel side
   input wire logic [IRQ_SRCS-1:0] in_service_latch
);
   // ******************
   // Bus pin properties
   // ******************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   // Synchroniser latency is two clocks, so six quiet clocks must release the bus
   AST_OE_RELEASE: assert property (data_strobe_n [*6] |=> !muxed_addr_data_oe)
      else $error("bus driven with data strobe high");
   AST_OE_DESELECT: assert property ((!chip_select_high && irq_ack_n) [*6] |=> !muxed_addr_data_oe)
      else $error("bus driven while deselected");
   AST_OE_CAUSE: assert property ($rose(muxed_addr_data_oe) |-> !$past(data_strobe_n, 2))
      else $error("bus driven without data strobe");
   AST_READ_DIR: assert property ($rose(muxed_addr_data_oe) |-> $past(rw, 2) || !irq_ack_n)
      else $error("bus driven on a write");
   AST_INT_DROP: assert property ($fell(data_strobe_n) && !irq_ack_n && chain_priority_in
      && !int_req_n |-> ##[1:8] int_req_n)
      else $error("request held after claim");
   AST_IUS_ACK: assert property ($rose(|in_service_latch)
      |-> !$past(irq_ack_n, 2) && !$past(data_strobe_n, 2))
      else $error("in-service set outside acknowledge");
   AST_IUS_CHAIN: assert property ($rose(|in_service_latch) |-> $past(chain_priority_in, 2))
      else $error("claim with chain input low");
   AST_PEND_AS: assert property ($fell(int_req_n) |-> $past(address_strobe_n, 3))
      else $error("request raised without address strobe");
endmodule : mhb_port_props
bind mhb_port mhb_port_props #(.IRQ_SRCS(IRQ_SRCS)) u_props (.sys_clk, .rstn,
   .address_strobe_n, .data_strobe_n, .chip_select_high, .rw, .irq_ack_n,
   .chain_priority_in, .muxed_addr_data_oe, .int_req_n, .in_service_latch);

// >>> mhb_host.sv
`timescale 1ns/1ps
module mhb_host (
   // Clock
   input wire logic sys_clk,
   // Bus pins toward the port
   output logic address_strobe_n,
   output logic data_strobe_n,
   output logic latched_select_low,
   output logic chip_select_high,
   output logic rw,
   output logic irq_ack_n,
   output logic [7:0] muxed_addr_data_in
);
   // ***************
   // Host bus cycles
   // ***************
   initial begin
      address_strobe_n = 1'b1;
      data_strobe_n = 1'b1;
      latched_select_low = 1'b1;
      chip_select_high = 1'b0;
      rw = 1'b1;
      irq_ack_n = 1'b1;
      muxed_addr_data_in = 8'h00;
   end
   // With ds_on low only the address strobe cycles, as for traffic to other parties
   task automatic cyc(input logic ack_n, input logic sel, input logic r,
      input logic [7:0] a, input logic [7:0] d, input logic ds_on);
      @(posedge sys_clk);
      address_strobe_n <= 1'b0;
      irq_ack_n <= ack_n;
      latched_select_low <= ~sel;
      muxed_addr_data_in <= a;
      repeat (2) @(posedge sys_clk);
      address_strobe_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      if (ds_on) begin
         rw <= r;
         chip_select_high <= sel;
         muxed_addr_data_in <= d;
         @(posedge sys_clk);
         data_strobe_n <= 1'b0;
         repeat (8) @(posedge sys_clk);
         data_strobe_n <= 1'b1;
      end
      @(posedge sys_clk);
      // Released lines show a changing pattern, never the old value
      muxed_addr_data_in <= ~d;
      chip_select_high <= 1'b0;
      irq_ack_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask : cyc
endmodule : mhb_host

// >>> multiplexed_host_bus_port_tb.sv
`timescale 1ns/1ps
module multiplexed_host_bus_port_tb;
   import mhb_pkg::*;
   logic sys_clk, rstn, chain_priority_in, muxed_addr_data_oe, int_req_n, access_overrun;
   wire logic address_strobe_n, data_strobe_n, latched_select_low, chip_select_high, rw;
   wire logic irq_ack_n;
   wire logic [7:0] muxed_addr_data_in;
   logic [3:0] irq_src, ius_clear, in_service_latch;
   logic [7:0] misc_status_in, muxed_addr_data_out, ext_write_settings, w;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h00007501;
   int fail_count = 0;
   int checked = 0;
   // *****************
   // Harness and tasks
   // *****************
   mhb_host u_host (.sys_clk, .address_strobe_n, .data_strobe_n, .latched_select_low,
      .chip_select_high, .rw, .irq_ack_n, .muxed_addr_data_in);
   mhb_port #(.IRQ_SRCS(4)) u_dut (.sys_clk, .rstn, .address_strobe_n, .data_strobe_n,
      .latched_select_low, .chip_select_high, .rw, .irq_ack_n, .chain_priority_in,
      .muxed_addr_data_in, .muxed_addr_data_out, .muxed_addr_data_oe, .int_req_n, .irq_src,
      .ius_clear, .misc_status_in, .in_service_latch, .ext_write_settings, .access_overrun);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : xs
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic summarize();
      if (fail_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // An unexpected drive finds the queue empty and fails against unknown
   always @(posedge muxed_addr_data_oe) begin
      #1;
      chk("read_data", muxed_addr_data_out, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      summarize();
   end
   // *************
   // Main sequence
   // *************
   initial begin
      rstn = 1'b0;
      chain_priority_in = 1'b1;
      irq_src = 4'h0;
      ius_clear = 4'h0;
      misc_status_in = 8'h00;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      w = xs();
      misc_status_in <= w;
      repeat (3) @(posedge sys_clk);
      exp_q.push_back(w);
      u_host.cyc(1'b1, 1'b1, 1'b1, ADDR_EXT_READBACK, 8'h00, 1'b1);
      w = xs() | 8'h80;
      u_host.cyc(1'b1, 1'b1, 1'b0, ADDR_EXT_WRITE, w, 1'b1);
      u_host.cyc(1'b1, 1'b0, 1'b0, ADDR_EXT_WRITE, ~w, 1'b1);
      chk("ext_write", ext_write_settings, w);
      u_host.cyc(1'b1, 1'b0, 1'b1, ADDR_EXT_WRITE, 8'h00, 1'b1);
      u_host.cyc(1'b1, 1'b1, 1'b0, ADDR_EXT_FEATURE, 8'h40, 1'b1);
      exp_q.push_back(w & 8'h7f);
      u_host.cyc(1'b1, 1'b1, 1'b1, ADDR_EXT_READBACK, 8'h00, 1'b1);
      u_host.cyc(1'b1, 1'b1, 1'b0, ADDR_IRQ_EN, 8'h0f, 1'b1);
      exp_q.push_back(8'h0f);
      u_host.cyc(1'b1, 1'b1, 1'b1, ADDR_IRQ_EN, 8'h00, 1'b1);
      exp_q.push_back(misc_status_in);
      u_host.cyc(1'b1, 1'b1, 1'b1, ADDR_MISC_STATUS, 8'h00, 1'b1);
      irq_src <= 4'b0010;
      u_host.cyc(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
      chk("irq_pending", {7'h00, int_req_n}, 8'h00);
      chain_priority_in <= 1'b0;
      u_host.cyc(1'b0, 1'b1, 1'b0, xs(), 8'h00, 1'b1);
      chk("ius_unclaimed", {4'h0, in_service_latch}, 8'h00);
      chain_priority_in <= 1'b1;
      exp_q.push_back(8'h02);
      u_host.cyc(1'b0, 1'b1, 1'b0, xs(), 8'h00, 1'b1);
      chk("ius_claimed", {4'h0, in_service_latch}, 8'h02);
      ius_clear <= 4'b0010;
      @(posedge sys_clk);
      ius_clear <= 4'h0;
      u_host.cyc(1'b1, 1'b1, 1'b0, ADDR_MASTER_IRQ_CTL, 8'h02, 1'b1);
      exp_q.push_back(8'h02);
      u_host.cyc(1'b1, 1'b1, 1'b1, ADDR_MASTER_IRQ_CTL, 8'h00, 1'b1);
      u_host.cyc(1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1);
      chk("ius_no_vector", {4'h0, in_service_latch}, 8'h02);
      chk("overrun", {7'h00, access_overrun}, 8'h00);
      chk("queue_left", 8'(exp_q.size()), 8'h00);
      summarize();
   end
endmodule : multiplexed_host_bus_port_tb
